// ==== core/pap_agent_end.sv ====
// Far agent end: makes bus_clk, initiates and answers as target.
// Assumes its user starts requests only when the bridge holds no grant.
`timescale 1ns/1ns
`default_nettype none
`include "pap_params.svh"

module pap_agent_end #(
	parameter int LINK_HALF = `PAP_LINK_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	pap_if.agent link,
	input wire logic wide64,
	input wire logic init_req,
	input wire pap_pkg::pap_cmd_type init_cmd,
	input wire pap_pkg::pap_word_type init_addr,
	input wire pap_pkg::pap_cbe_type init_be,
	input wire pap_pkg::pap_word_type init_wdata,
	output logic init_busy,
	output logic init_done,
	output pap_pkg::pap_word_type init_rdata,
	input wire pap_pkg::pap_word_type tgt_rdata,
	input wire pap_pkg::pap_cbe_type tgt_rd_be,
	output logic tgt_valid,
	output pap_pkg::pap_word_type tgt_wdata
);
	import pap_pkg::*;

	// Peer sees edges through three flops; a shorter half breaks sampling
	if (LINK_HALF < 4 || LINK_HALF > 255)
	begin : g_half_check
		$error("LINK_HALF out of range");
	end

	// =========================================
	// Clock divider, sampling on rise, driving on fall
	logic [7:0] div_reg;
	logic clk_reg;
	logic rise;
	logic fall;
	logic [76:0] s1_reg; // First stage, read only by second
	logic [76:0] s2_reg;
	logic [76:0] snap_reg; // Lines captured at rise
	logic frame_d_reg;
	pap_word_type b_ad;
	pap_cbe_type b_cbe;
	logic b_frame;
	logic xfer;
	logic [1:0] half_oe_n;

	assign rise = (div_reg == 8'(LINK_HALF - 1)) & ~clk_reg;
	assign fall = (div_reg == 8'(LINK_HALF - 1)) & clk_reg;

	// Divide the system clock to the bus clock
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			div_reg <= 8'h00;
			clk_reg <= 1'b0;
		end
		else if (div_reg == 8'(LINK_HALF - 1))
		begin
			div_reg <= 8'h00;
			clk_reg <= ~clk_reg;
		end
		else
			div_reg <= div_reg + 8'h01;
	end

	// Synchronise the lines and hold them per bus edge
	always_ff @(posedge clk_sys)
	begin
		s1_reg <= {link.frame_l, link.irdy_l, link.trdy_l, link.par, link.cbe, link.ad};
		s2_reg <= s1_reg;
		if (!rst_n)
		begin
			snap_reg <= '1;
			frame_d_reg <= 1'b1;
		end
		else if (rise)
		begin
			snap_reg <= s2_reg;
			frame_d_reg <= snap_reg[76];
		end
	end

	assign b_ad = snap_reg[63:0];
	assign b_cbe = snap_reg[71:64];
	assign b_frame = snap_reg[76];
	assign xfer = ~snap_reg[75] & ~snap_reg[74];
	assign half_oe_n = {~wide64, 1'b0};

	// =========================================
	// Sequencer and pin drivers
	pap_state_type state_reg;
	logic rq_write_reg;
	pap_word_type rq_addr_reg;
	pap_cbe_type rq_be_reg;
	pap_word_type rq_wdata_reg;
	pap_cmd_type rq_cmd_reg;
	pap_word_type ad_o_reg;
	logic [1:0] ad_oe_n_reg;
	pap_cbe_type cbe_o_reg;
	logic [1:0] cbe_oe_n_reg;
	logic [1:0] par_o_reg;
	logic [1:0] par_oe_n_reg;
	logic [2:0] ctl_o_reg;
	logic [2:0] ctl_oe_n_reg;

	// Same walk as the bridge, changing pins on falls
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_reg <= PAP_IDLE;
			{rq_write_reg, rq_cmd_reg, rq_addr_reg, rq_be_reg, rq_wdata_reg} <= '0;
			{ad_o_reg, cbe_o_reg, par_o_reg} <= '0;
			{ad_oe_n_reg, cbe_oe_n_reg, par_oe_n_reg} <= '1;
			ctl_o_reg <= 3'h7;
			ctl_oe_n_reg <= 3'h7;
			{init_busy, init_done, tgt_valid} <= 3'h0;
			init_rdata <= 64'h0000000000000000;
			tgt_wdata <= 64'h0000000000000000;
		end
		else
		begin
			init_done <= 1'b0;
			tgt_valid <= 1'b0;
			if (init_req && !init_busy)
			begin
				init_busy <= 1'b1;
				rq_cmd_reg <= init_cmd;
				rq_write_reg <= init_cmd[`PAP_CMD_WRITE_BIT];
				rq_addr_reg <= init_addr;
				rq_be_reg <= init_be;
				rq_wdata_reg <= init_wdata;
			end
			if (fall)
			begin
				unique case (state_reg)
					PAP_IDLE:
					begin
						if (~b_frame & frame_d_reg)
						begin
							// Target of a bridge transaction
							par_o_reg <= pap_par2(b_ad, b_cbe);
							par_oe_n_reg <= half_oe_n;
							ctl_o_reg <= 3'h6;
							ctl_oe_n_reg <= 3'h6;
							ad_o_reg <= tgt_rdata;
							cbe_o_reg <= tgt_rd_be;
							ad_oe_n_reg <= b_cbe[`PAP_CMD_WRITE_BIT] ? `PAP_HALVES_OFF : half_oe_n;
							cbe_oe_n_reg <= b_cbe[`PAP_CMD_WRITE_BIT] ? `PAP_HALVES_OFF : half_oe_n;
							state_reg <= PAP_T_DATA;
						end
						else if (init_busy && b_frame && snap_reg[75])
						begin
							// Address and command with frame
							ad_o_reg <= rq_addr_reg;
							cbe_o_reg <= {rq_cmd_reg, rq_cmd_reg};
							ad_oe_n_reg <= half_oe_n;
							cbe_oe_n_reg <= half_oe_n;
							ctl_o_reg <= 3'h3;
							ctl_oe_n_reg <= 3'h1;
							state_reg <= PAP_I_ADDR;
						end
					end
					PAP_I_ADDR:
					begin
						ctl_o_reg <= 3'h5;
						ad_o_reg <= rq_wdata_reg;
						cbe_o_reg <= rq_be_reg;
						ad_oe_n_reg <= rq_write_reg ? half_oe_n : `PAP_HALVES_OFF;
						cbe_oe_n_reg <= rq_write_reg ? half_oe_n : `PAP_HALVES_OFF;
						state_reg <= PAP_I_DATA;
					end
					PAP_I_DATA:
					begin
						if (xfer)
						begin
							init_rdata <= b_ad;
							init_done <= 1'b1;
							ctl_o_reg <= 3'h7;
							ad_oe_n_reg <= `PAP_HALVES_OFF;
							cbe_oe_n_reg <= `PAP_HALVES_OFF;
							state_reg <= PAP_I_LAST;
						end
					end
					PAP_I_LAST:
					begin
						ctl_oe_n_reg <= 3'h7;
						init_busy <= 1'b0;
						state_reg <= PAP_IDLE;
					end
					PAP_T_DATA:
					begin
						par_o_reg <= pap_par2(b_ad, b_cbe);
						if (xfer)
						begin
							tgt_wdata <= b_ad;
							tgt_valid <= 1'b1;
							ctl_o_reg <= 3'h7;
							ad_oe_n_reg <= `PAP_HALVES_OFF;
							cbe_oe_n_reg <= `PAP_HALVES_OFF;
							state_reg <= PAP_T_PAR;
						end
					end
					PAP_T_PAR:
					begin
						par_oe_n_reg <= `PAP_HALVES_OFF;
						ctl_oe_n_reg <= 3'h7;
						state_reg <= PAP_IDLE;
					end
					default:
						state_reg <= PAP_IDLE;
				endcase
			end
		end
	end

	// Pins straight from flip-flops
	assign link.bus_clk = clk_reg;
	assign link.ag_ad_o = ad_o_reg;
	assign link.ag_ad_oe_n = ad_oe_n_reg;
	assign link.ag_cbe_o = cbe_o_reg;
	assign link.ag_cbe_oe_n = cbe_oe_n_reg;
	assign link.ag_par_o = par_o_reg;
	assign link.ag_par_oe_n = par_oe_n_reg;
	assign link.ag_ctl_o = ctl_o_reg;
	assign link.ag_ctl_oe_n = ctl_oe_n_reg;
endmodule // pap_agent_end

`default_nettype wire

// ==== core/pap_bridge_end.sv ====
// Bridge end of the address/data, command and parity port.
// Assumes the agent makes bus_clk and that bus_grant arbitrates the bus.
`timescale 1ns/1ns
`default_nettype none
`include "pap_params.svh"

// Notes on behaviour
// - Address phase is first clock of frame low
// - Data phase aligns with irdy or trdy
// - Word moves only when irdy and trdy low
// - Parked idle bus: drive ad, cbe, parity
// - Initiator drives command during address phase
// - Write: initiator drives enables; else target does
// - Lower parity even over ad[31:0], cbe[3:0]
// - Upper parity even over ad[63:32], cbe[7:4]
// - Bridge initiating a write leaves parity undriven
// - Bridge write target drives parity one clock later
// - Bridge read target drives parity one clock later
// - Bridge target releases parity one clock after ad released
module pap_bridge_end (
	input wire logic clk_sys,
	input wire logic rst_n,
	pap_if.bridge link,
	input wire logic wide64,
	input wire logic bus_grant,
	input wire logic init_req,
	input wire pap_pkg::pap_cmd_type init_cmd,
	input wire pap_pkg::pap_word_type init_addr,
	input wire pap_pkg::pap_cbe_type init_be,
	input wire pap_pkg::pap_word_type init_wdata,
	output logic init_busy,
	output logic init_done,
	output pap_pkg::pap_word_type init_rdata,
	input wire pap_pkg::pap_word_type tgt_rdata,
	input wire pap_pkg::pap_cbe_type tgt_rd_be,
	output logic tgt_valid,
	output pap_pkg::pap_cmd_type tgt_cmd,
	output pap_pkg::pap_word_type tgt_addr,
	output pap_pkg::pap_word_type tgt_wdata,
	output pap_pkg::pap_cbe_type tgt_wbe
);
	import pap_pkg::*;

	// =========================================
	// Pin synchronisers and edge finding
	logic [77:0] s1_reg; // First stage, read only by second
	logic [77:0] s2_reg; // Second stage
	logic clk_d_reg; // Previous bus clock level
	logic frame_d_reg; // Frame at previous bus edge
	pap_word_type b_ad;
	pap_cbe_type b_cbe;
	logic b_trdy;
	logic b_irdy;
	logic b_frame;
	logic b_clk;
	logic tick; // One-cycle pulse per bus rising edge
	logic addr_phase; // First edge with frame low
	logic xfer; // Irdy and trdy both low
	logic [1:0] half_oe_n; // Lanes allowed for this width

	// Two flip-flops on every incoming line
	always_ff @(posedge clk_sys)
	begin
		s1_reg <= {link.bus_clk, link.frame_l, link.irdy_l, link.trdy_l, link.par, link.cbe, link.ad};
		s2_reg <= s1_reg;
	end

	assign b_ad = s2_reg[63:0];
	assign b_cbe = s2_reg[71:64];
	assign b_trdy = s2_reg[74];
	assign b_irdy = s2_reg[75];
	assign b_frame = s2_reg[76];
	assign b_clk = s2_reg[77];
	assign tick = b_clk & ~clk_d_reg;
	assign addr_phase = ~b_frame & frame_d_reg;
	assign xfer = ~b_irdy & ~b_trdy;
	assign half_oe_n = {~wide64, 1'b0};

	// Clock edge and frame history
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			clk_d_reg <= 1'b0;
			frame_d_reg <= 1'b1;
		end
		else
		begin
			clk_d_reg <= b_clk;
			if (tick)
				frame_d_reg <= b_frame;
		end
	end

	// =========================================
	// Request capture
	pap_cmd_type rq_cmd_reg;
	pap_word_type rq_addr_reg;
	pap_cbe_type rq_be_reg;
	pap_word_type rq_wdata_reg;
	logic rq_write;

	// Hold the request while busy
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rq_cmd_reg <= 4'h0;
			rq_addr_reg <= 64'h0000000000000000;
			rq_be_reg <= 8'h00;
			rq_wdata_reg <= 64'h0000000000000000;
		end
		else if (init_req && !init_busy)
		begin
			rq_cmd_reg <= init_cmd;
			rq_addr_reg <= init_addr;
			rq_be_reg <= init_be;
			rq_wdata_reg <= init_wdata;
		end
	end

	assign rq_write = rq_cmd_reg[`PAP_CMD_WRITE_BIT];

	// =========================================
	// Sequencer and pin drivers
	pap_state_type state_reg;
	logic tg_write_reg; // Write seen as target
	pap_word_type ad_o_reg;
	logic [1:0] ad_oe_n_reg;
	pap_cbe_type cbe_o_reg;
	logic [1:0] cbe_oe_n_reg;
	logic [1:0] par_o_reg;
	logic [1:0] par_oe_n_reg;
	logic [2:0] ctl_o_reg; // Frame, irdy, trdy
	logic [2:0] ctl_oe_n_reg;

	// Walk each transaction on bus edges
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_reg <= PAP_IDLE;
			tg_write_reg <= 1'b0;
			ad_o_reg <= 64'h0000000000000000;
			ad_oe_n_reg <= `PAP_HALVES_OFF;
			cbe_o_reg <= 8'h00;
			cbe_oe_n_reg <= `PAP_HALVES_OFF;
			par_o_reg <= 2'h0;
			par_oe_n_reg <= `PAP_HALVES_OFF;
			ctl_o_reg <= 3'h7;
			ctl_oe_n_reg <= 3'h7;
			init_busy <= 1'b0;
			init_done <= 1'b0;
			init_rdata <= 64'h0000000000000000;
			tgt_valid <= 1'b0;
			tgt_cmd <= 4'h0;
			tgt_addr <= 64'h0000000000000000;
			tgt_wdata <= 64'h0000000000000000;
			tgt_wbe <= 8'h00;
		end
		else
		begin
			// Pulses last one cycle
			init_done <= 1'b0;
			tgt_valid <= 1'b0;
			if (init_req && !init_busy)
				init_busy <= 1'b1;
			if (tick)
			begin
				unique case (state_reg)
					PAP_IDLE:
					begin
						if (addr_phase)
						begin
							// Target: latch command, answer with parity next edge
							tgt_cmd <= b_cbe[3:0];
							tgt_addr <= wide64 ? b_ad : {32'h00000000, b_ad[31:0]};
							tg_write_reg <= b_cbe[`PAP_CMD_WRITE_BIT];
							par_o_reg <= pap_par2(b_ad, b_cbe);
							par_oe_n_reg <= half_oe_n;
							ctl_o_reg <= 3'h6;
							ctl_oe_n_reg <= 3'h6;
							ad_o_reg <= tgt_rdata;
							cbe_o_reg <= tgt_rd_be;
							ad_oe_n_reg <= b_cbe[`PAP_CMD_WRITE_BIT] ? `PAP_HALVES_OFF : half_oe_n;
							cbe_oe_n_reg <= b_cbe[`PAP_CMD_WRITE_BIT] ? `PAP_HALVES_OFF : half_oe_n;
							state_reg <= PAP_T_DATA;
						end
						else if (init_busy && bus_grant && b_frame && b_irdy)
						begin
							// Initiator: address and command with frame
							ad_o_reg <= rq_addr_reg;
							cbe_o_reg <= {rq_cmd_reg, rq_cmd_reg};
							ad_oe_n_reg <= half_oe_n;
							cbe_oe_n_reg <= half_oe_n;
							par_oe_n_reg <= `PAP_HALVES_OFF;
							ctl_o_reg <= 3'h3;
							ctl_oe_n_reg <= 3'h1;
							state_reg <= PAP_I_ADDR;
						end
						else if (bus_grant && b_frame && b_irdy)
						begin
							// Parked: every lane at a valid level
							ad_o_reg <= `PAP_PARK_AD;
							cbe_o_reg <= `PAP_PARK_CBE;
							par_o_reg <= pap_par2(`PAP_PARK_AD, `PAP_PARK_CBE);
							ad_oe_n_reg <= 2'h0;
							cbe_oe_n_reg <= 2'h0;
							par_oe_n_reg <= 2'h0;
							ctl_oe_n_reg <= 3'h7;
						end
						else
						begin
							// Idle and not parked: release
							ad_oe_n_reg <= `PAP_HALVES_OFF;
							cbe_oe_n_reg <= `PAP_HALVES_OFF;
							par_oe_n_reg <= `PAP_HALVES_OFF;
							ctl_oe_n_reg <= 3'h7;
						end
					end
					PAP_I_ADDR:
					begin
						// Single data phase: frame off, irdy on
						ctl_o_reg <= 3'h5;
						ad_o_reg <= rq_wdata_reg;
						cbe_o_reg <= rq_be_reg;
						ad_oe_n_reg <= rq_write ? half_oe_n : `PAP_HALVES_OFF;
						cbe_oe_n_reg <= rq_write ? half_oe_n : `PAP_HALVES_OFF;
						state_reg <= PAP_I_DATA;
					end
					PAP_I_DATA:
					begin
						if (xfer)
						begin
							// Word moved: irdy high one edge, lanes off
							init_rdata <= b_ad;
							init_done <= 1'b1;
							ctl_o_reg <= 3'h7;
							ad_oe_n_reg <= `PAP_HALVES_OFF;
							cbe_oe_n_reg <= `PAP_HALVES_OFF;
							state_reg <= PAP_I_LAST;
						end
					end
					PAP_I_LAST:
					begin
						// Release control lines
						ctl_oe_n_reg <= 3'h7;
						init_busy <= 1'b0;
						state_reg <= PAP_IDLE;
					end
					PAP_T_DATA:
					begin
						// Parity trails the lanes by one edge
						par_o_reg <= pap_par2(b_ad, b_cbe);
						if (xfer)
						begin
							tgt_wdata <= b_ad;
							tgt_wbe <= b_cbe;
							tgt_valid <= 1'b1;
							ctl_o_reg <= 3'h7;
							ad_oe_n_reg <= `PAP_HALVES_OFF;
							cbe_oe_n_reg <= `PAP_HALVES_OFF;
							state_reg <= PAP_T_PAR;
						end
					end
					PAP_T_PAR:
					begin
						// Parity and trdy off one edge after ad
						par_oe_n_reg <= `PAP_HALVES_OFF;
						ctl_oe_n_reg <= 3'h7;
						state_reg <= PAP_IDLE;
					end
					default:
						state_reg <= PAP_IDLE;
				endcase
			end
		end
	end

	// Pins straight from flip-flops
	assign link.br_ad_o = ad_o_reg;
	assign link.br_ad_oe_n = ad_oe_n_reg;
	assign link.br_cbe_o = cbe_o_reg;
	assign link.br_cbe_oe_n = cbe_oe_n_reg;
	assign link.br_par_o = par_o_reg;
	assign link.br_par_oe_n = par_oe_n_reg;
	assign link.br_ctl_o = ctl_o_reg;
	assign link.br_ctl_oe_n = ctl_oe_n_reg;
endmodule // pap_bridge_end

`default_nettype wire

// ==== core/pap_if.sv ====
// Pin bundle joining the bridge end and the agent end.
// Assumes nothing else drives these pins; undriven lines pull high.
`timescale 1ns/1ns
`default_nettype none

interface pap_if;
	// =========================================
	// Resolved bus lines
	logic bus_clk; // Bus feedback clock, made by the agent
	logic [63:0] ad;
	logic [7:0] cbe;
	logic [1:0] par; // Bit 0 lower parity, bit 1 upper parity
	logic frame_l;
	logic irdy_l;
	logic trdy_l;
	// =========================================
	// Bridge drivers, enables low while driving
	logic [63:0] br_ad_o;
	logic [1:0] br_ad_oe_n;
	logic [7:0] br_cbe_o;
	logic [1:0] br_cbe_oe_n;
	logic [1:0] br_par_o;
	logic [1:0] br_par_oe_n;
	logic [2:0] br_ctl_o; // Frame, irdy, trdy
	logic [2:0] br_ctl_oe_n;
	// =========================================
	// Agent drivers, enables low while driving
	logic [63:0] ag_ad_o;
	logic [1:0] ag_ad_oe_n;
	logic [7:0] ag_cbe_o;
	logic [1:0] ag_cbe_oe_n;
	logic [1:0] ag_par_o;
	logic [1:0] ag_par_oe_n;
	logic [2:0] ag_ctl_o;
	logic [2:0] ag_ctl_oe_n;

	// Wire resolution with pull-ups
	assign ad[31:0] = !br_ad_oe_n[0] ? br_ad_o[31:0] : (!ag_ad_oe_n[0] ? ag_ad_o[31:0] : '1);
	assign ad[63:32] = !br_ad_oe_n[1] ? br_ad_o[63:32] : (!ag_ad_oe_n[1] ? ag_ad_o[63:32] : '1);
	assign cbe[3:0] = !br_cbe_oe_n[0] ? br_cbe_o[3:0] : (!ag_cbe_oe_n[0] ? ag_cbe_o[3:0] : '1);
	assign cbe[7:4] = !br_cbe_oe_n[1] ? br_cbe_o[7:4] : (!ag_cbe_oe_n[1] ? ag_cbe_o[7:4] : '1);
	assign par[0] = !br_par_oe_n[0] ? br_par_o[0] : (!ag_par_oe_n[0] ? ag_par_o[0] : 1'b1);
	assign par[1] = !br_par_oe_n[1] ? br_par_o[1] : (!ag_par_oe_n[1] ? ag_par_o[1] : 1'b1);
	assign frame_l = !br_ctl_oe_n[2] ? br_ctl_o[2] : (!ag_ctl_oe_n[2] ? ag_ctl_o[2] : 1'b1);
	assign irdy_l = !br_ctl_oe_n[1] ? br_ctl_o[1] : (!ag_ctl_oe_n[1] ? ag_ctl_o[1] : 1'b1);
	assign trdy_l = !br_ctl_oe_n[0] ? br_ctl_o[0] : (!ag_ctl_oe_n[0] ? ag_ctl_o[0] : 1'b1);

	modport bridge (input bus_clk, ad, cbe, par, frame_l, irdy_l, trdy_l,
		output br_ad_o, br_ad_oe_n, br_cbe_o, br_cbe_oe_n, br_par_o, br_par_oe_n,
		br_ctl_o, br_ctl_oe_n);
	modport agent (output bus_clk, input ad, cbe, par, frame_l, irdy_l, trdy_l,
		output ag_ad_o, ag_ad_oe_n, ag_cbe_o, ag_cbe_oe_n, ag_par_o, ag_par_oe_n,
		ag_ctl_o, ag_ctl_oe_n);
endinterface // pap_if

`default_nettype wire

// ==== core/pap_params.svh ====
// Constants for the 64-bit address/data, command and parity port.
// Assumes inclusion by bare name from the package and the end modules.
`ifndef PAP_PARAMS_SVH
`define PAP_PARAMS_SVH

// =========================================
// Command decoding
`define PAP_CMD_WRITE_BIT 0
`define PAP_CMD_MEM_READ 4'h6
`define PAP_CMD_MEM_WRITE 4'h7

// =========================================
// Values driven while the bus is parked
`define PAP_PARK_AD 64'h0000000000000000
`define PAP_PARK_CBE 8'h00

// =========================================
// Enable codes (low means the pin is driven)
`define PAP_HALVES_OFF 2'h3

// =========================================
// Timing
`define PAP_SYS_PERIOD_NS 20
`define PAP_LINK_PERIOD_NS 160
`define PAP_LINK_HALF_CYC (`PAP_LINK_PERIOD_NS / (2 * `PAP_SYS_PERIOD_NS))

`endif

// ==== core/pap_pkg.sv ====
// Types and parity helper shared by both ends of the port.
// Assumes pap_params.svh is on the include path.
`include "pap_params.svh"

package pap_pkg;
	// Bus word, command/enable lanes and command code
	typedef logic [63:0] pap_word_type;
	typedef logic [7:0] pap_cbe_type;
	typedef logic [3:0] pap_cmd_type;

	// Sequencer states of either end
	typedef enum logic [2:0] {
		PAP_IDLE = 3'b000,
		PAP_I_ADDR = 3'b001,
		PAP_I_DATA = 3'b010,
		PAP_I_LAST = 3'b011,
		PAP_T_DATA = 3'b100,
		PAP_T_PAR = 3'b101
	} pap_state_type;

	// Even parity of both halves: bit 0 lower, bit 1 upper
	function automatic logic [1:0] pap_par2(input pap_word_type d, input pap_cbe_type c);
		pap_par2 = {^{d[63:32], c[7:4]}, ^{d[31:0], c[3:0]}};
	endfunction
endpackage

// ==== testbench/pap_port_sva.sv ====
// Checker for the address/data, command and parity pins.
// Assumes the bench instantiates it beside the pap_if bundle.
`timescale 1ns/1ns
`default_nettype none

module pap_port_sva (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic bus_clk,
	input wire logic [63:0] ad,
	input wire logic [7:0] cbe,
	input wire logic [1:0] par,
	input wire logic frame_l,
	input wire logic irdy_l,
	input wire logic trdy_l,
	input wire logic [1:0] br_ad_oe_n,
	input wire logic [1:0] br_cbe_oe_n,
	input wire logic [1:0] br_par_oe_n,
	input wire logic [2:0] br_ctl_oe_n,
	input wire logic [1:0] ag_par_oe_n,
	input wire logic wide64 // Both ends set for 64-bit transfers
);
	// =========================================
	// Bus edge finder and last-phase store
	logic bclk_reg; // Bus clock one cycle ago
	logic rise; // Rising bus edge seen
	logic [63:0] ad_reg; // Lines at last bus edge
	logic [7:0] cbe_reg; // Lanes at last bus edge
	logic frame_reg; // Frame at last bus edge
	logic ad_off_reg; // Bridge lower lines released at last edge
	assign rise = bus_clk && !bclk_reg;

	// Keep the lines of the previous bus edge
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			bclk_reg <= 1'b0;
			ad_reg <= '1;
			cbe_reg <= '1;
			frame_reg <= 1'b1;
			ad_off_reg <= 1'b1;
		end
		else
		begin
			bclk_reg <= bus_clk;
			if (rise)
			begin
				ad_reg <= ad;
				cbe_reg <= cbe;
				frame_reg <= frame_l;
				ad_off_reg <= br_ad_oe_n[0];
			end
		end
	end

	// =========================================
	// Pin relations
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	par_low_even_a: assert property (rise && !(br_par_oe_n[0] && ag_par_oe_n[0]) |->
		par[0] == ^{ad_reg[31:0], cbe_reg[3:0]}) else $error("lower parity wrong");
	par_high_even_a: assert property (rise && !(br_par_oe_n[1] && ag_par_oe_n[1]) |->
		par[1] == ^{ad_reg[63:32], cbe_reg[7:4]}) else $error("upper parity wrong");
	init_par_off_a: assert property (rise && !br_ctl_oe_n[1] |-> br_par_oe_n == 2'h3)
		else $error("initiating bridge drives parity");
	addr_phase_a: assert property (rise && !frame_l && frame_reg |-> irdy_l && trdy_l
		##8 (rise && !irdy_l && frame_l)) else $error("address or data phase misplaced");
	one_word_a: assert property (rise && !irdy_l && !trdy_l |->
		##8 (rise && irdy_l && trdy_l)) else $error("transfer not closed");
	tgt_par_a: assert property (rise && !trdy_l && !br_ctl_oe_n[0] |->
		!br_par_oe_n[0] ##8 !br_par_oe_n[0]) else $error("target parity not driven");
	par_release_a: assert property (rise && br_ad_oe_n[0] && !ad_off_reg |->
		##8 br_par_oe_n[0]) else $error("parity not released");
	park_lanes_a: assert property (rise && frame_l && irdy_l && br_ctl_oe_n == 3'h7
		&& !br_ad_oe_n[0] |-> {br_ad_oe_n, br_cbe_oe_n, br_par_oe_n} == 6'h00)
		else $error("parked lanes not all driven");
	upper_lanes_a: assert property (!br_ad_oe_n[1] |-> wide64 || br_ctl_oe_n == 3'h7)
		else $error("upper lines driven on narrow transfer");
endmodule // pap_port_sva

`default_nettype wire

// ==== testbench/pci_ad_cbe_parity_port_tb.sv ====
// Bench joining bridge end and agent end over one pin bundle.
// Assumes the design files and pap_params.svh are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "pap_params.svh"

module pci_ad_cbe_parity_port_tb;
	import pap_pkg::*;
	// =========================================
	// Stimulus and observed signals
	logic clk_sys, rst_n, wide64, bus_grant, b_req, a_req;
	pap_cmd_type cmd, bc_cmd, b_tcmd; // Shared command, capture
	pap_word_type addr, wdata, rdata, b_rd, a_rd, b_taddr, b_twd, a_twd, bc_addr, bc_wd, ac_wd, rd;
	pap_cbe_type be, rd_be, b_twbe, bc_be; // Lanes
	logic b_busy, b_done, b_tv, a_busy, a_done, a_tv; // Handshakes
	int fails, compares, cyc;
	pap_if link_if();

	pap_bridge_end pap_bridge_end_i (.clk_sys, .rst_n, .link(link_if), .wide64, .bus_grant,
		.init_req(b_req), .init_cmd(cmd), .init_addr(addr), .init_be(be), .init_wdata(wdata),
		.init_busy(b_busy), .init_done(b_done), .init_rdata(b_rd), .tgt_rdata(rdata),
		.tgt_rd_be(rd_be), .tgt_valid(b_tv), .tgt_cmd(b_tcmd), .tgt_addr(b_taddr),
		.tgt_wdata(b_twd), .tgt_wbe(b_twbe));
	pap_agent_end pap_agent_end_i (.clk_sys, .rst_n, .link(link_if), .wide64,
		.init_req(a_req), .init_cmd(cmd), .init_addr(addr), .init_be(be), .init_wdata(wdata),
		.init_busy(a_busy), .init_done(a_done), .init_rdata(a_rd), .tgt_rdata(rdata),
		.tgt_rd_be(rd_be), .tgt_valid(a_tv), .tgt_wdata(a_twd));
	pap_port_sva pap_port_sva_i (.clk_sys, .rst_n, .bus_clk(link_if.bus_clk), .ad(link_if.ad),
		.cbe(link_if.cbe), .par(link_if.par), .frame_l(link_if.frame_l),
		.irdy_l(link_if.irdy_l), .trdy_l(link_if.trdy_l), .br_ad_oe_n(link_if.br_ad_oe_n),
		.br_cbe_oe_n(link_if.br_cbe_oe_n), .br_par_oe_n(link_if.br_par_oe_n),
		.br_ctl_oe_n(link_if.br_ctl_oe_n), .ag_par_oe_n(link_if.ag_par_oe_n), .wide64);

	// Clock at 50 MHz
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Target captures and cycle ceiling
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (b_tv)
		begin
			bc_cmd <= b_tcmd;
			bc_addr <= b_taddr;
			bc_wd <= b_twd;
			bc_be <= b_twbe;
		end
		if (a_tv)
			ac_wd <= a_twd;
		if (cyc == 4000)
		begin
			fails++;
			wrap_up();
		end
	end

	// =========================================
	// Shared tasks
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	// One transaction from either end, then idle bus edges
	task automatic xfer(input logic from_br, input pap_cmd_type c, input pap_word_type d);
		int n;
		// Grant only when the bridge starts; a parked bridge must release first
		bus_grant = from_br;
		repeat (16) tick();
		cmd = c;
		addr = ~d;
		wdata = d;
		be = 8'hA5;
		rdata = {d[31:0], d[63:32]};
		if (from_br)
			b_req = 1'b1;
		else
			a_req = 1'b1;
		tick();
		b_req = 1'b0;
		a_req = 1'b0;
		n = 0;
		while (!(from_br ? b_done : a_done) && n < 300)
		begin
			tick();
			n++;
		end
		rd = from_br ? b_rd : a_rd;
		check(64'(n < 300), 64'h1, "no completion");
		repeat (32) tick();
	endtask

	task automatic wrap_up();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// =========================================
	// Scenarios
	task automatic park_scn();
		bus_grant = 1'b1;
		repeat (40) tick();
		check(link_if.ad, `PAP_PARK_AD, "park ad");
		check(64'(link_if.cbe), 64'(`PAP_PARK_CBE), "park lanes");
		check(64'(link_if.par), 64'h0, "park parity");
		bus_grant = 1'b0;
		repeat (40) tick();
	endtask

	task automatic br_write_scn();
		xfer(1'b1, `PAP_CMD_MEM_WRITE, 64'h0123456789ABCDEF);
		check(ac_wd, wdata, "agent write data");
	endtask

	task automatic br_read_scn();
		xfer(1'b1, `PAP_CMD_MEM_READ, 64'hFEDCBA9876543210);
		check(rd, rdata, "bridge read data");
	endtask

	task automatic ag_write_scn();
		xfer(1'b0, `PAP_CMD_MEM_WRITE, 64'h8000000100000001);
		check(64'(bc_cmd), 64'(`PAP_CMD_MEM_WRITE), "bridge command");
		check(bc_addr, addr, "bridge address");
		check(bc_wd, wdata, "bridge write data");
		check(64'(bc_be), 64'(be), "bridge lanes");
	endtask

	task automatic ag_read_scn();
		xfer(1'b0, `PAP_CMD_MEM_READ, 64'h00FF00FF5A5A5A5A);
		check(64'(bc_cmd), 64'(`PAP_CMD_MEM_READ), "bridge read command");
		check(rd, rdata, "agent read data");
	endtask

	task automatic narrow_scn();
		wide64 = 1'b0;
		xfer(1'b0, `PAP_CMD_MEM_WRITE, 64'h1111111122222222);
		check(64'(bc_wd[31:0]), 64'(wdata[31:0]), "narrow write");
		check(64'(bc_wd[63:32]), 64'hFFFFFFFF, "narrow upper idle");
		xfer(1'b1, `PAP_CMD_MEM_READ, 64'h3333333344444444);
		check(64'(rd[31:0]), 64'(rdata[31:0]), "narrow read");
		check(64'(rd[63:32]), 64'hFFFFFFFF, "narrow read upper idle");
		wide64 = 1'b1;
	endtask

	// Main sequence
	initial
	begin
		{rst_n, b_req, a_req, bus_grant, cmd, addr, wdata, be, rdata} = '0;
		{fails, compares, cyc} = '0;
		wide64 = 1'b1;
		rd_be = 8'h0F;
		repeat (5) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		repeat (4) tick();
		park_scn();
		br_write_scn();
		br_read_scn();
		ag_write_scn();
		ag_read_scn();
		narrow_scn();
		wrap_up();
	end
endmodule // pci_ad_cbe_parity_port_tb

`default_nettype wire
